/* common/hbridge_params.svh */
`ifndef HBRIDGE_PARAMS_SVH
`define HBRIDGE_PARAMS_SVH
// clock rate in kHz
`define CLK_KHZ 10000
// timings in nanoseconds, as printed
`define BLANK_NS 1800
`define OFF_NS 21000
`define DEAD_NS 250
`define OCP_GLITCH_NS 1400
`define WAKE_NS 140000
// cycle counts: least times round up, longest round down
`define BLANK_CYC ((`BLANK_NS * `CLK_KHZ + 999999) / 1000000)
`define OFF_CYC ((`OFF_NS * `CLK_KHZ + 999999) / 1000000)
`define DEAD_CYC ((`DEAD_NS * `CLK_KHZ + 999999) / 1000000)
`define OCP_GLITCH_CYC ((`OCP_GLITCH_NS * `CLK_KHZ + 999999) / 1000000)
`define WAKE_CYC ((`WAKE_NS * `CLK_KHZ) / 1000000)
// over-current retry period in cycles (plain default)
`define RETRY_CYC 1000
`endif

/* common/hbridge_pkg.sv */
`default_nettype none
package hbridge_pkg;
    // drive state of one half-bridge arm
    typedef enum logic [1:0] {
        ARM_OFF = 2'b00,
        ARM_HIGH = 2'b01,
        ARM_LOW = 2'b10
    } arm_t;
    // chopper phases
    typedef enum logic [1:0] {
        CH_ON = 2'b00,
        CH_DECAY = 2'b01,
        CH_TRIPPED = 2'b10
    } chop_t;
    // switch gate pair of one arm
    typedef struct packed {
        logic hiOn;
        logic loOn;
    } gates_t;
    // one bridge output: two arms
    typedef struct packed {
        gates_t pos;
        gates_t neg;
    } bridge_t;
endpackage
`default_nettype wire

/* sim/dual_hbridge_chopper_control_tb.sv */
`default_nettype none
module dual_hbridge_chopper_control_tb
    import hbridge_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAKE = 20; // shortened wake wait
    localparam logic [3:0] FWD = 4'hD; // pos high, neg low
    localparam logic [3:0] REV = 4'h7; // pos low, neg high
    // clock, reset and host wishes
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wantAwake = 1'b0;
    logic [1:0] wantDir = 2'h0;
    // analog indications
    logic bridge_a_current_sense = 1'b0;
    logic bridge_b_current_sense = 1'b0;
    logic [1:0] overcurrent_guard = 2'h0;
    logic overheat_shutdown = 1'b0;
    logic supply_low_lockout = 1'b0;
    // pins and outputs
    logic low_power_request_n, bridge_a_direction_in, bridge_b_direction_in;
    logic ready;
    bridge_t bridge_a_gates, bridge_b_gates;
    logic bridge_a_out_pos, bridge_a_out_pos_oe, bridge_a_out_neg;
    logic bridge_a_out_neg_oe, bridge_b_out_pos, bridge_b_out_pos_oe;
    logic bridge_b_out_neg, bridge_b_out_neg_oe, fault_out, fault_oe;
    int miscompares = 0;
    int checks = 0;
    // pin view {pos, pos_oe, neg, neg_oe}
    wire logic [3:0] outA = {bridge_a_out_pos, bridge_a_out_pos_oe,
        bridge_a_out_neg, bridge_a_out_neg_oe};
    wire logic [3:0] outB = {bridge_b_out_pos, bridge_b_out_pos_oe,
        bridge_b_out_neg, bridge_b_out_neg_oe};
    hbridge_host_model #(.WAKE(WAKE)) host (.clk, .rstn, .wantAwake,
        .wantDir, .low_power_request_n, .bridge_a_direction_in,
        .bridge_b_direction_in, .ready);
    dual_hbridge_chopper_control #(.WAKE(WAKE), .RETRY(30)) dut (.clk,
        .rstn, .low_power_request_n, .bridge_a_direction_in,
        .bridge_b_direction_in, .bridge_a_current_sense,
        .bridge_b_current_sense, .overcurrent_guard, .overheat_shutdown,
        .supply_low_lockout, .bridge_a_gates, .bridge_b_gates,
        .bridge_a_out_pos, .bridge_a_out_pos_oe, .bridge_a_out_neg,
        .bridge_a_out_neg_oe, .bridge_b_out_pos, .bridge_b_out_pos_oe,
        .bridge_b_out_neg, .bridge_b_out_neg_oe, .fault_out, .fault_oe);
    // 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // signal watched by a bounded wait
    function automatic logic sel(input int k);
        case (k)
            0: return ready;
            1: return fault_oe;
            2: return bridge_a_gates.pos.hiOn;
            default: return bridge_a_out_pos_oe;
        endcase
    endfunction
    // a wait that runs out counts as a mismatch and ends the run
    task automatic wait_for(input int k, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && sel(k) !== v; i++) cyc(1);
        if (i == lim) begin
            miscompares++;
            end_sim();
        end
    endtask
    task automatic s_sleep();
        wantDir <= 2'h3;
        cyc(10);
        check(outA, 4'h0);
        check(outB, 4'h0);
        wantAwake <= 1'b1;
        cyc(8);
        check(outA, 4'h0);
        wait_for(0, 1'b1, WAKE + 40);
        check(outB, FWD);
    endtask
    task automatic s_dir();
        for (int i = 0; i < 4; i++) begin
            wantDir <= 2'(i);
            cyc(12);
            check(outA, i[0] ? FWD : REV);
            check(outB, i[1] ? FWD : REV);
        end
    endtask
    // sense held high: chop repeats, high side kept through blanking
    task automatic s_chop();
        int n;
        bridge_a_current_sense <= 1'b1;
        wait_for(2, 1'b0, 40);
        cyc(10);
        check({bridge_a_gates.pos.loOn, bridge_a_gates.neg.loOn}, 2'h3);
        for (n = 10; n < 300 && bridge_a_gates.pos.hiOn !== 1'b1; n++) cyc(1);
        check(n >= 210 && n <= 218, 1'b1);
        for (n = 0; n < 99 && bridge_a_gates.pos.hiOn === 1'b1; n++) cyc(1);
        check(n >= 18 && n <= 24, 1'b1);
        bridge_a_current_sense <= 1'b0;
        cyc(240);
        check(outA, FWD);
    endtask
    // over-current on A only, no sense trip involved
    task automatic s_oc();
        overcurrent_guard <= 2'h1;
        wait_for(1, 1'b1, 30);
        cyc(2);
        check(outA, 4'h0);
        check(outB, FWD);
        overcurrent_guard <= 2'h0;
        wait_for(1, 1'b0, 45);
        cyc(12);
        check(outA, FWD);
    endtask
    task automatic s_heat();
        overheat_shutdown <= 1'b1;
        cyc(5);
        check({fault_oe, fault_out, outA, outB}, 10'h200);
        overheat_shutdown <= 1'b0;
        cyc(12);
        check({fault_oe, outA}, {1'b0, FWD});
    endtask
    task automatic s_low();
        supply_low_lockout <= 1'b1;
        cyc(4);
        check({fault_oe, outA, outB}, 9'h100);
        supply_low_lockout <= 1'b0;
        wait_for(3, 1'b1, WAKE + 60);
        cyc(4);
        check(outB, FWD);
    endtask
    initial begin
        cyc(5);
        rstn <= 1'b1;
        s_sleep();
        s_dir();
        s_chop();
        s_oc();
        s_heat();
        s_low();
        end_sim();
    end
endmodule
`default_nettype wire

/* sim/hbridge_host_model.sv */
`default_nettype none
module hbridge_host_model #(
    parameter int WAKE = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // wanted pin levels
    input wire logic wantAwake,
    input wire logic [1:0] wantDir,
    // device pins
    output logic low_power_request_n,
    output logic bridge_a_direction_in,
    output logic bridge_b_direction_in,
    // outputs may be trusted
    output logic ready
);
    timeunit 1ns;
    timeprecision 1ns;
    int waitCnt; // cycles since wake request
    // pins change just after the edge; ready carries slack for sync stages
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_power_request_n <= 1'b0;
            bridge_a_direction_in <= 1'b0;
            bridge_b_direction_in <= 1'b0;
            waitCnt <= 0;
            ready <= 1'b0;
        end else begin
            low_power_request_n <= wantAwake;
            bridge_a_direction_in <= wantDir[0];
            bridge_b_direction_in <= wantDir[1];
            if (!wantAwake) begin
                waitCnt <= 0;
            end else if (waitCnt < WAKE + 14) begin
                waitCnt <= waitCnt + 1;
            end
            ready <= wantAwake && waitCnt >= WAKE + 14;
        end
    end
endmodule
`default_nettype wire

/* sim/hbridge_sva.sv */
`default_nettype none
module hbridge_sva
    import hbridge_pkg::*;
#(
    parameter int WAKE = 20,
    parameter int RETRY = 30
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // host and analog inputs
    input wire logic low_power_request_n,
    input wire logic overheat_shutdown,
    input wire logic supply_low_lockout,
    // bridge outputs
    input wire bridge_t bridge_a_gates,
    input wire bridge_t bridge_b_gates,
    input wire logic bridge_a_out_pos,
    input wire logic bridge_a_out_pos_oe,
    input wire logic bridge_a_out_neg_oe,
    input wire logic bridge_b_out_pos_oe,
    input wire logic bridge_b_out_neg_oe,
    // fault pin
    input wire logic fault_out,
    input wire logic fault_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // any arm of either bridge driving its pin
    wire logic anyOe = bridge_a_out_pos_oe | bridge_a_out_neg_oe |
        bridge_b_out_pos_oe | bridge_b_out_neg_oe;
    int wakeCnt; // cycles awake, saturates at WAKE
    // sleep restarts the count, so a short wake never counts as done
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wakeCnt <= 0;
        end else if (!low_power_request_n) begin
            wakeCnt <= 0;
        end else if (wakeCnt < WAKE) begin
            wakeCnt <= wakeCnt + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_sleep_float: assert property (
        !low_power_request_n [*3] |-> !anyOe)
        else $error("outputs driven in sleep");
    a_wake_hold: assert property (
        low_power_request_n && wakeCnt < WAKE |-> !anyOe)
        else $error("outputs driven before wake-up ends");
    a_supply_off: assert property (
        supply_low_lockout [*4] |-> !anyOe && fault_oe)
        else $error("supply low not handled");
    a_heat_fault: assert property (
        overheat_shutdown [*4] |-> fault_oe)
        else $error("fault not pulled low when hot");
    a_heat_off: assert property (
        overheat_shutdown [*4] |-> !anyOe)
        else $error("switches on when hot");
    a_fault_od: assert property (!fault_out)
        else $error("fault pin driven high");
    a_level_match: assert property (
        bridge_a_out_pos == bridge_a_gates.pos.hiOn &&
        bridge_a_out_pos_oe == (bridge_a_gates.pos.hiOn |
        bridge_a_gates.pos.loOn))
        else $error("pin level disagrees with gates");
    a_no_both_high: assert property (
        !(bridge_a_gates.pos.hiOn && bridge_a_gates.neg.hiOn) &&
        !(bridge_b_gates.pos.hiOn && bridge_b_gates.neg.hiOn))
        else $error("both high sides on");
    a_dead_gap: assert property (
        $fell(bridge_a_gates.pos.loOn) |-> !bridge_a_gates.pos.hiOn [*2])
        else $error("no dead time in arm");
endmodule
bind dual_hbridge_chopper_control hbridge_sva #(
    .WAKE(WAKE),
    .RETRY(RETRY)
) chk (
    .clk, .rstn, .low_power_request_n, .overheat_shutdown,
    .supply_low_lockout, .bridge_a_gates, .bridge_b_gates,
    .bridge_a_out_pos, .bridge_a_out_pos_oe, .bridge_a_out_neg_oe,
    .bridge_b_out_pos_oe, .bridge_b_out_neg_oe, .fault_out, .fault_oe
);
`default_nettype wire

/* verilog/arm_deadtime.sv */
`include "hbridge_params.svh"
`default_nettype none
module arm_deadtime
    import hbridge_pkg::*;
#(
    parameter int DEAD = `DEAD_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // requested arm state
    input wire arm_t want,
    // gate outputs
    output gates_t gates
);
    // refused at elaboration: the 8-bit counter holds 1 to 255
    if (DEAD < 1 || DEAD > 255)
        $error("dead time out of range");
    typedef struct packed {
        arm_t cur;
        logic [7:0] cnt;
        gates_t g;
    } st_t;
    st_t s_q, s_d;
    // both switches off for at least DEAD + 2 cycles between changes
    always_comb begin
        s_d = s_q;
        if (want != s_q.cur) begin
            s_d.g = '0;
            if (s_q.cur != ARM_OFF && want != ARM_OFF) begin
                // crossing: pass through off first
                s_d.cur = ARM_OFF;
                s_d.cnt = 8'(DEAD);
            end else if (s_q.cnt != 8'h00) begin
                s_d.cnt = s_q.cnt - 8'h01;
            end else begin
                s_d.cur = want;
                s_d.cnt = 8'(DEAD);
            end
        end else begin
            if (s_q.cnt != 8'h00 && s_q.cur == ARM_OFF)
                s_d.cnt = s_q.cnt - 8'h01;
            s_d.g.hiOn = (s_q.cur == ARM_HIGH);
            s_d.g.loOn = (s_q.cur == ARM_LOW);
        end
    end
    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{cur: ARM_OFF, cnt: 8'h00, g: 2'b00};
        end else begin
            s_q <= s_d;
        end
    end
    assign gates = s_q.g;
endmodule
`default_nettype wire

/* verilog/bridge_chopper.sv */
`include "hbridge_params.svh"
`default_nettype none
module bridge_chopper
    import hbridge_pkg::*;
#(
    parameter int BLANK = `BLANK_CYC,
    parameter int OFFT = `OFF_CYC,
    parameter int GLITCH = `OCP_GLITCH_CYC,
    parameter int RETRY = `RETRY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // synchronised controls
    input wire logic run,
    input wire logic dirIn,
    input wire logic senseTrip,
    input wire logic limitActive,
    // arm requests and fault
    output arm_t wantPos,
    output arm_t wantNeg,
    output logic ocFault
);
    // refused at elaboration: the 16-bit timers cannot hold these
    if (BLANK < 1 || OFFT < 1 || GLITCH < 1 || RETRY < 1 ||
        RETRY > 65535 || OFFT > 65535 || BLANK + `DEAD_CYC + 1 > 65535)
        $error("bridge_chopper count out of range");
    // blank runs from the arm request, but the high side turns on only
    // after the dead-time path; stretch the mask so on-time >= BLANK
    localparam int ONBLANK = BLANK + `DEAD_CYC + 1;
    typedef struct packed {
        chop_t ph;
        logic dir;
        logic [15:0] tmr;
        logic [15:0] ocCnt;
        logic ocOff;
    } st_t;
    st_t s_q, s_d;
    // chopper and over-current sequencing
    always_comb begin
        s_d = s_q;
        if (s_q.tmr != 16'h0000)
            s_d.tmr = s_q.tmr - 16'h0001;
        if (!run) begin
            s_d.ph = CH_ON;
            s_d.tmr = 16'(ONBLANK);
            s_d.dir = dirIn;
        end else if (s_q.ocOff) begin
            // retry wait, then re-enable
            if (s_q.tmr == 16'h0000) begin
                s_d.ocOff = 1'b0;
                s_d.ocCnt = '0;
                s_d.ph = CH_ON;
                s_d.tmr = 16'(ONBLANK);
            end
        end else if (limitActive && s_q.ocCnt >= 16'(GLITCH - 1)) begin
            // limit outlasts deglitch: this bridge only
            s_d.ocOff = 1'b1;
            s_d.tmr = 16'(RETRY);
        end else begin
            s_d.ocCnt = limitActive ? s_q.ocCnt + 16'h0001 : 16'h0000;
            if (dirIn != s_q.dir) begin
                // outputs switch: new blanking
                s_d.dir = dirIn;
                s_d.ph = CH_ON;
                s_d.tmr = 16'(ONBLANK);
            end else begin
                case (s_q.ph)
                    CH_ON: begin
                        // trip ignored while blanking
                        if (s_q.tmr == 16'h0000 && senseTrip) begin
                            s_d.ph = CH_DECAY;
                            s_d.tmr = 16'(OFFT);
                        end
                    end
                    CH_DECAY: begin
                        // fixed off-time then on again
                        if (s_q.tmr == 16'h0000) begin
                            s_d.ph = CH_ON;
                            s_d.tmr = 16'(ONBLANK);
                        end
                    end
                    default: s_d.ph = CH_ON;
                endcase
            end
        end
    end
    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{ph: CH_ON, dir: 1'b0, tmr: 16'h0000,
                     ocCnt: 16'h0000, ocOff: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end
    // arm requests: forward drives pos high
    always_comb begin
        wantPos = ARM_OFF;
        wantNeg = ARM_OFF;
        if (run && !s_q.ocOff) begin
            if (s_q.ph == CH_DECAY) begin
                // slow decay: both low sides
                wantPos = ARM_LOW;
                wantNeg = ARM_LOW;
            end else begin
                wantPos = s_q.dir ? ARM_HIGH : ARM_LOW;
                wantNeg = s_q.dir ? ARM_LOW : ARM_HIGH;
            end
        end
    end
    assign ocFault = s_q.ocOff;
endmodule
`default_nettype wire

/* verilog/dual_hbridge_chopper_control.sv */
`include "hbridge_params.svh"
`default_nettype none
module dual_hbridge_chopper_control
    import hbridge_pkg::*;
#(
    parameter int WAKE = `WAKE_CYC,
    parameter int RETRY = `RETRY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // host pins
    input wire logic low_power_request_n,
    input wire logic bridge_a_direction_in,
    input wire logic bridge_b_direction_in,
    // analog indications
    input wire logic bridge_a_current_sense,
    input wire logic bridge_b_current_sense,
    input wire logic [1:0] overcurrent_guard,
    input wire logic overheat_shutdown,
    input wire logic supply_low_lockout,
    // bridge gates
    output bridge_t bridge_a_gates,
    output bridge_t bridge_b_gates,
    // output levels and enables
    output logic bridge_a_out_pos,
    output logic bridge_a_out_pos_oe,
    output logic bridge_a_out_neg,
    output logic bridge_a_out_neg_oe,
    output logic bridge_b_out_pos,
    output logic bridge_b_out_pos_oe,
    output logic bridge_b_out_neg,
    output logic bridge_b_out_neg_oe,
    // open-drain fault
    output logic fault_out,
    output logic fault_oe
);
    // refused at elaboration: the wake timer is 16 bits wide
    if (WAKE < 1 || WAKE > 65535)
        $error("wake count out of range");
    localparam int NSYNC = 7;
    // all state of this level except the guard synchronisers
    typedef struct packed {
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic [15:0] wake;
        logic awake;
        logic faultLow;
    } st_t;
    st_t s_q, s_d;
    logic [NSYNC-1:0] raw;
    logic sleepN, dirA, dirB, senA, senB, ocA, ocB, hot, uvLow;
    logic localRst, hold, run;
    logic ocFaultA, ocFaultB;
    arm_t wApos, wAneg, wBpos, wBneg;
    bridge_t gA, gB;
    // pins gathered for two-flop synchronisation
    assign raw = {low_power_request_n, bridge_a_direction_in,
                  bridge_b_direction_in, bridge_a_current_sense,
                  bridge_b_current_sense, overheat_shutdown,
                  supply_low_lockout};
    assign {sleepN, dirA, dirB, senA, senB, hot, uvLow} = s_q.s2;
    // guard inputs sampled through a dedicated pair
    logic [1:0] oc1_q, oc2_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oc1_q <= 2'b00;
            oc2_q <= 2'b00;
        end else begin
            oc1_q <= overcurrent_guard;
            oc2_q <= oc1_q;
        end
    end
    assign ocA = oc2_q[0];
    assign ocB = oc2_q[1];
    // wake timer and fault level
    always_comb begin
        s_d = s_q;
        s_d.s1 = raw;
        s_d.s2 = s_q.s1;
        if (!sleepN || uvLow) begin
            // sleep and lockout reset the logic
            s_d.wake = 16'(WAKE);
            s_d.awake = 1'b0;
        end else if (s_q.wake != 16'h0000) begin
            // ignore inputs until woken
            s_d.wake = s_q.wake - 16'h0001;
        end else begin
            s_d.awake = 1'b1;
        end
        // fault low on heat outside sleep, lockout or over-current
        s_d.faultLow = (sleepN && hot) || uvLow || ocFaultA || ocFaultB;
    end
    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{s1: '0, s2: '0, wake: 16'h0000,
                     awake: 1'b0, faultLow: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end
    // internal reset of both bridges
    assign localRst = rstn && sleepN && !uvLow;
    // overheat holds switches off without reset
    assign hold = hot;
    assign run = s_q.awake && !hold;
    // bridge A follows its own input
    bridge_chopper #(.RETRY(RETRY)) chopA (
        .clk(clk),
        .rstn(localRst),
        .run(run),
        .dirIn(dirA),
        .senseTrip(senA),
        .limitActive(ocA),
        .wantPos(wApos),
        .wantNeg(wAneg),
        .ocFault(ocFaultA)
    );
    // bridge B follows its own input
    bridge_chopper #(.RETRY(RETRY)) chopB (
        .clk(clk),
        .rstn(localRst),
        .run(run),
        .dirIn(dirB),
        .senseTrip(senB),
        .limitActive(ocB),
        .wantPos(wBpos),
        .wantNeg(wBneg),
        .ocFault(ocFaultB)
    );
    // dead-time arms, one per output
    arm_deadtime armAp (.clk(clk), .rstn(localRst), .want(wApos),
                        .gates(gA.pos));
    arm_deadtime armAn (.clk(clk), .rstn(localRst), .want(wAneg),
                        .gates(gA.neg));
    arm_deadtime armBp (.clk(clk), .rstn(localRst), .want(wBpos),
                        .gates(gB.pos));
    arm_deadtime armBn (.clk(clk), .rstn(localRst), .want(wBneg),
                        .gates(gB.neg));
    assign bridge_a_gates = gA;
    assign bridge_b_gates = gB;
    // pin view: driven when either switch is on, else floating
    assign bridge_a_out_pos = gA.pos.hiOn;
    assign bridge_a_out_pos_oe = gA.pos.hiOn | gA.pos.loOn;
    assign bridge_a_out_neg = gA.neg.hiOn;
    assign bridge_a_out_neg_oe = gA.neg.hiOn | gA.neg.loOn;
    assign bridge_b_out_pos = gB.pos.hiOn;
    assign bridge_b_out_pos_oe = gB.pos.hiOn | gB.pos.loOn;
    assign bridge_b_out_neg = gB.neg.hiOn;
    assign bridge_b_out_neg_oe = gB.neg.hiOn | gB.neg.loOn;
    // open drain: only ever pulls low
    assign fault_out = 1'b0;
    assign fault_oe = s_q.faultLow;
endmodule
`default_nettype wire
